// ==== src/slave_ctl_map.vh ====
// What this block does
// - xor select feeds channel 1 filter with xor of three channel pins
// - xor result serves trigger selection and input capture alike
// - reset mode on both-edge source restarts counter on any input toggle
// - channel 1 source select 11 captures count on combined trigger
// - channel 2 compare mode 111, source 00 gives pwm mode 2 output
// - master mode 101 puts channel 2 reference on master trigger out
// - channel 2 pulse after programmed delay leaves via master trigger out
// - preload and commutation select both set: trigger edge transfers control bits
// - reset mode trigger clears counter and prescaler, update if source low
// - slave modes 100 reset, 101 gated, 110 trigger; select 101 input1, 110 input2
// - reset trigger sets trigger flag, irq or dma request when enabled
// - counter control acts only after resynchronised trigger edges
// - polarity 0/0 rising, 1/0 falling or low; filter 0000 means none
// - gated mode counts while trigger level active and count run set
// - gated mode sets trigger flag at start and at stop
// - trigger mode edge starts the counter and sets trigger flag
// - external clock mode 2 combines with slave modes, ext pin clocks counter
// - ext filter 0000 none, prescale 00 none, polarity 0 rising, enable 1
// - clock mode 2 plus trigger: edge enables, ext rising edges then count
// - debug halt freezes counter when halt freeze select is set
// - trigger mode sets count run in hardware; other modes need software
`ifndef SLAVE_CTL_MAP_VH
`define SLAVE_CTL_MAP_VH
`define SMS_OFF      3'h0
`define SMS_RESET    3'h4
`define SMS_GATED    3'h5
`define SMS_TRIGGER  3'h6
`define TS_ED        3'h4
`define TS_IN1       3'h5
`define TS_IN2       3'h6
`define TS_EXT       3'h7
`define SRC_OUT      2'h0
`define SRC_COMBINED 2'h3
`define OCM_PWM2     3'h7
`define MMS_CH2REF   3'h5
`define MMS_UPDATE   3'h2
`define MMS_ENABLE   3'h1
`define CNT_RESET    16'h0000
`define ARR_RESET    16'hFFFF
`endif

// ==== src/timer_slave_mode_control.v ====
`timescale 1ns/10ps
`include "slave_ctl_map.vh"
module timer_slave_mode_control
(
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // pins
    input  wire        ch1_pin,
    input  wire        ch2_pin,
    input  wire        ch3_pin,
    input  wire        ext_trigger_pin,
    input  wire        core_halted,
    // configuration
    input  wire        input_xor_select,
    input  wire [3:0]  ch1_input_filter,
    input  wire        ch1_polarity,
    input  wire        ch1_polarity_comp,
    input  wire [3:0]  ch2_input_filter,
    input  wire        ch2_polarity,
    input  wire [1:0]  ch1_source_select,
    input  wire [1:0]  ch2_source_select,
    input  wire [2:0]  ch2_compare_mode,
    input  wire [15:0] ch2_compare,
    input  wire [15:0] auto_reload,
    input  wire [15:0] prescale,
    input  wire [2:0]  master_mode_select,
    input  wire [2:0]  slave_mode_select,
    input  wire [2:0]  trigger_select,
    input  wire        update_request_source,
    input  wire        trigger_irq_enable,
    input  wire        trigger_dma_enable,
    input  wire        compare_ctrl_preload,
    input  wire        commutation_update_select,
    input  wire [3:0]  ext_trigger_filter,
    input  wire [1:0]  ext_trigger_prescale,
    input  wire        ext_trigger_polarity,
    input  wire        ext_clock2_enable,
    input  wire        halt_freeze_select,
    // software strobes
    input  wire        count_run_set,
    input  wire        count_run_clear,
    input  wire        trigger_flag_clear,
    // status
    output reg  [15:0] count_q,
    output reg  [15:0] ch1_capture_q,
    output reg         ch1_capture_flag_q,
    output reg         count_run_q,
    output reg         trigger_flag_q,
    output reg         trigger_irq_q,
    output reg         trigger_dma_q,
    output reg         update_event_q,
    output reg         commutation_q,
    output reg         ch2_reference_out_q,
    output reg         master_trigger_out_q
);

    reg  [1:0]  s1_q;
    reg  [1:0]  s2_q;
    reg  [1:0]  s3_q;
    reg  [1:0]  se_q;
    reg  [3:0]  f1_cnt_q;
    reg  [3:0]  f2_cnt_q;
    reg  [3:0]  fe_cnt_q;
    reg         f1_q;
    reg         f2_q;
    reg         fe_q;
    reg         f1_prev_q;
    reg         f2_prev_q;
    reg         fe_prev_q;
    reg         trig_prev_q;
    reg  [1:0]  ext_div_q;
    reg  [15:0] psc_q;
    reg  [15:0] arr_q;
    reg  [15:0] cmp_q;

    // two flop resynchronisation of the channel and ext trigger pins
    always @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
            s3_q <= 2'h0;
            se_q <= 2'h0;
        end
        else
        begin
            s1_q <= {s1_q[0], ch1_pin};
            s2_q <= {s2_q[0], ch2_pin};
            s3_q <= {s3_q[0], ch3_pin};
            se_q <= {se_q[0], ext_trigger_pin};
        end
    end

    wire in1_raw = input_xor_select ? (s1_q[1] ^ s2_q[1] ^ s3_q[1]) : s1_q[1];

    // digital filter: level must hold for n + 1 samples; n = 0 passes at once
    function [4:0] filt;
        input [3:0] n;
        input [3:0] cnt;
        input       raw;
        input       cur;
        begin
            if (raw == cur)
                filt = {cur, 4'h0};
            else if (cnt >= n)
                filt = {raw, 4'h0};
            else
                filt = {cur, cnt + 4'h1};
        end
    endfunction

    always @(posedge clk)
    begin
        if (reset)
        begin
            f1_q <= 1'b0;
            f2_q <= 1'b0;
            fe_q <= 1'b0;
            f1_cnt_q <= 4'h0;
            f2_cnt_q <= 4'h0;
            fe_cnt_q <= 4'h0;
            f1_prev_q <= 1'b0;
            f2_prev_q <= 1'b0;
            fe_prev_q <= 1'b0;
        end
        else
        begin
            {f1_q, f1_cnt_q} <= filt(ch1_input_filter, f1_cnt_q, in1_raw, f1_q);
            {f2_q, f2_cnt_q} <= filt(ch2_input_filter, f2_cnt_q, s2_q[1], f2_q);
            {fe_q, fe_cnt_q} <= filt(ext_trigger_filter, fe_cnt_q, se_q[1], fe_q);
            f1_prev_q <= f1_q;
            f2_prev_q <= f2_q;
            fe_prev_q <= fe_q;
        end
    end

    // polarity: 0 keeps the level, 1 inverts it
    function pol;
        input lvl;
        input inv;
        begin
            pol = lvl ^ inv;
        end
    endfunction

    // rising edge of a polarity corrected level
    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    // polarity: 0 rising/high, 1 falling/low
    wire in1_fp = pol(f1_q, ch1_polarity);
    wire in1_prev_fp = pol(f1_prev_q, ch1_polarity);
    wire in2_fp = pol(f2_q, ch2_polarity);
    wire in2_prev_fp = pol(f2_prev_q, ch2_polarity);
    wire ext_fp = pol(fe_q, ext_trigger_polarity);
    wire ext_prev_fp = pol(fe_prev_q, ext_trigger_polarity);
    wire both_edge = f1_q ^ f1_prev_q;

    reg trig_level;
    reg trig_edge;
    always @*
    begin
        trig_level = 1'b0;
        trig_edge = 1'b0;
        case (trigger_select)
            `TS_ED:
            begin
                trig_level = both_edge;
                trig_edge = both_edge;
            end
            `TS_IN1:
            begin
                trig_level = in1_fp;
                trig_edge = rise(in1_fp, in1_prev_fp);
            end
            `TS_IN2:
            begin
                trig_level = in2_fp;
                trig_edge = rise(in2_fp, in2_prev_fp);
            end
            `TS_EXT:
            begin
                trig_level = ext_fp;
                trig_edge = rise(ext_fp, ext_prev_fp);
            end
            default:
            begin
                trig_level = 1'b0;
                trig_edge = 1'b0;
            end
        endcase
    end

    // external clock mode 2 tick, optionally divided by 2 or 4
    wire ext_rise = rise(ext_fp, ext_prev_fp);
    reg ext_tick;
    always @*
    begin
        case (ext_trigger_prescale)
            2'h0: ext_tick = ext_rise;
            2'h1: ext_tick = ext_rise & ext_div_q[0];
            2'h2: ext_tick = ext_rise & (&ext_div_q);
            default: ext_tick = ext_rise & (&ext_div_q);
        endcase
    end

    wire is_reset = (slave_mode_select == `SMS_RESET);
    wire is_gated = (slave_mode_select == `SMS_GATED);
    wire is_trig = (slave_mode_select == `SMS_TRIGGER);
    wire slave_hit = is_reset & trig_edge;
    wire gate_open = is_gated ? trig_level : 1'b1;
    wire gate_turn = is_gated & (trig_level != trig_prev_q) & count_run_q;
    wire frozen = core_halted & halt_freeze_select;
    wire cnt_en = count_run_q & gate_open & ~frozen;
    wire base_tick = ext_clock2_enable ? ext_tick : 1'b1;
    wire psc_done = (psc_q == prescale);
    wire cnt_tick = cnt_en & base_tick & psc_done;
    wire overflow = cnt_tick & (count_q == arr_q);
    wire upd = overflow | (slave_hit & ~update_request_source);
    wire trig_evt = slave_hit | gate_turn | (is_trig & trig_edge);

    always @(posedge clk)
    begin
        if (reset)
        begin
            count_q <= `CNT_RESET;
            psc_q <= 16'h0000;
            arr_q <= `ARR_RESET;
            cmp_q <= 16'h0000;
            ext_div_q <= 2'h0;
            count_run_q <= 1'b0;
            trig_prev_q <= 1'b0;
            trigger_flag_q <= 1'b0;
            trigger_irq_q <= 1'b0;
            trigger_dma_q <= 1'b0;
            update_event_q <= 1'b0;
            commutation_q <= 1'b0;
            ch1_capture_q <= 16'h0000;
            ch1_capture_flag_q <= 1'b0;
            ch2_reference_out_q <= 1'b0;
            master_trigger_out_q <= 1'b0;
        end
        else
        begin
            trig_prev_q <= trig_level;
            if (ext_rise)
                ext_div_q <= ext_div_q + 2'h1;
            if (is_trig & trig_edge)
                count_run_q <= 1'b1;
            else if (count_run_clear)
                count_run_q <= 1'b0;
            else if (count_run_set)
                count_run_q <= 1'b1;
            if (slave_hit)
            begin
                count_q <= `CNT_RESET;
                psc_q <= 16'h0000;
            end
            else if (cnt_en & base_tick)
            begin
                psc_q <= psc_done ? 16'h0000 : psc_q + 16'h0001;
                if (psc_done)
                    count_q <= (count_q == arr_q) ? `CNT_RESET : count_q + 16'h0001;
            end
            if (upd)
            begin
                arr_q <= auto_reload;
                cmp_q <= ch2_compare;
            end
            update_event_q <= upd;
            // set wins over software clear
            if (trig_evt)
                trigger_flag_q <= 1'b1;
            else if (trigger_flag_clear)
                trigger_flag_q <= 1'b0;
            trigger_irq_q <= trig_evt & trigger_irq_enable;
            trigger_dma_q <= trig_evt & trigger_dma_enable;
            commutation_q <= compare_ctrl_preload & commutation_update_select & trig_edge;
            if (trig_edge & (ch1_source_select == `SRC_COMBINED))
            begin
                ch1_capture_q <= count_q;
                ch1_capture_flag_q <= 1'b1;
            end
            else if (trigger_flag_clear)
                ch1_capture_flag_q <= 1'b0;
            // pwm mode 2: high once count reaches compare
            if ((ch2_source_select == `SRC_OUT) & (ch2_compare_mode == `OCM_PWM2))
                ch2_reference_out_q <= (count_q >= cmp_q);
            else
                ch2_reference_out_q <= 1'b0;
            case (master_mode_select)
                `MMS_CH2REF: master_trigger_out_q <= ch2_reference_out_q;
                `MMS_UPDATE: master_trigger_out_q <= upd;
                `MMS_ENABLE: master_trigger_out_q <= cnt_en;
                default: master_trigger_out_q <= 1'b0;
            endcase
        end
    end

endmodule // timer_slave_mode_control

// ==== verif/hall_source.sv ====
`timescale 1ns/10ps
module hall_source
(
    // timing
    input  wire       clk,
    // requests
    input  wire [1:0] toggle_sel,
    input  wire       toggle,
    input  wire       ext_run,
    // pins
    output reg  [2:0] hall_q,
    output reg        ext_q
);
    reg [1:0] phase_q = 2'h0;
    initial hall_q = 3'h0;
    initial ext_q = 1'h0;
    // one sensor changes per request, like a real hall sequence
    always @(negedge clk)
    begin
        if (toggle)
            hall_q[toggle_sel] <= ~hall_q[toggle_sel];
        // ext clock idles low outside a burst, period of 4 clocks inside
        phase_q <= ext_run ? phase_q + 2'h1 : 2'h0;
        ext_q   <= ext_run & phase_q[1];
    end
endmodule // hall_source

// ==== verif/timer_slave_mode_control_properties.sv ====
`timescale 1ns/10ps
module slave_ctl_checker
(
    // clock and reset
    input wire        clk,
    input wire        reset,
    // inputs
    input wire        ch1_pin,
    input wire        ch2_pin,
    input wire        ch3_pin,
    input wire        core_halted,
    input wire        input_xor_select,
    input wire [3:0]  ch1_input_filter,
    input wire [2:0]  master_mode_select,
    input wire [2:0]  slave_mode_select,
    input wire [2:0]  trigger_select,
    input wire        trigger_irq_enable,
    input wire        trigger_dma_enable,
    input wire        halt_freeze_select,
    // outputs
    input wire [15:0] count_q,
    input wire        count_run_q,
    input wire        trigger_flag_q,
    input wire        trigger_irq_q,
    input wire        trigger_dma_q,
    input wire        ch2_reference_out_q,
    input wire        master_trigger_out_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_clears: assert property (disable iff (1'h0) reset |=> !count_q && !trigger_flag_q && !count_run_q)
        else $error("state survives reset");
    a_hall_restart: assert property (slave_mode_select == 3'h4 && trigger_select == 3'h4 && input_xor_select
        && ch1_input_filter == 4'h0 && $changed(ch1_pin ^ ch2_pin ^ ch3_pin) |-> ##[2:5] count_q == 16'h0000)
        else $error("hall toggle did not restart counter");
    a_irq_follows: assert property (trigger_irq_q |-> trigger_flag_q && trigger_irq_enable)
        else $error("irq without flag or enable");
    a_dma_follows: assert property (trigger_dma_q |-> trigger_flag_q && trigger_dma_enable)
        else $error("dma without flag or enable");
    a_gate_no_run: assert property (slave_mode_select == 3'h5 && !count_run_q |=> $stable(count_q))
        else $error("gated count without run bit");
    a_trig_run: assert property ($rose(trigger_flag_q) && slave_mode_select == 3'h6 |-> ##[0:1] count_run_q)
        else $error("trigger did not start counter");
    a_halt_freeze: assert property ((core_halted && halt_freeze_select)[*2] |=> $stable(count_q))
        else $error("counter moved while halted");
    a_mms_ch2ref: assert property ((master_mode_select == 3'h5)[*2] |-> master_trigger_out_q == ch2_reference_out_q
        || master_trigger_out_q == $past(ch2_reference_out_q))
        else $error("master out not channel 2 reference");
    a_mms_other: assert property ((master_mode_select == 3'h3)[*2] |-> !master_trigger_out_q)
        else $error("master out active in unlisted mode");
    c_irq: cover property (trigger_irq_q);
    c_master: cover property ($rose(master_trigger_out_q));
    c_gate_stop: cover property (slave_mode_select == 3'h5 && $fell(count_run_q));
endmodule // slave_ctl_checker
bind timer_slave_mode_control slave_ctl_checker slave_ctl_checker_inst (.*);

// ==== verif/timer_slave_mode_control_tb_top.sv ====
`timescale 1ns/10ps
module timer_slave_mode_control_tb_top;
    reg clk, reset, core_halted, input_xor_select, ch1_polarity, ch1_polarity_comp, ch2_polarity;
    reg update_request_source, trigger_irq_enable, trigger_dma_enable, compare_ctrl_preload, toggle;
    reg commutation_update_select, ext_trigger_polarity, ext_clock2_enable, halt_freeze_select, ext_run;
    reg count_run_set, count_run_clear, trigger_flag_clear;
    reg [3:0] ch1_input_filter, ch2_input_filter, ext_trigger_filter;
    reg [1:0] ch1_source_select, ch2_source_select, ext_trigger_prescale, toggle_sel;
    reg [2:0] ch2_compare_mode, master_mode_select, slave_mode_select, trigger_select;
    reg [15:0] ch2_compare, auto_reload, prescale, c1;
    wire [15:0] count_q, ch1_capture_q;
    wire ch1_pin, ch2_pin, ch3_pin, ext_trigger_pin, ch1_capture_flag_q, count_run_q, trigger_flag_q;
    wire trigger_irq_q, trigger_dma_q, update_event_q, commutation_q, ch2_reference_out_q, master_trigger_out_q;
    integer mismatches = 0, num_checks = 0, n_irq = 0, n_dma = 0, n_upd = 0, n_com = 0;
    timer_slave_mode_control timer_slave_mode_control_inst (.*);
    hall_source hall_source_inst (.clk(clk), .toggle_sel(toggle_sel), .toggle(toggle), .ext_run(ext_run),
        .hall_q({ch3_pin, ch2_pin, ch1_pin}), .ext_q(ext_trigger_pin));
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        {core_halted, input_xor_select, ch1_polarity, ch1_polarity_comp, ch2_polarity, toggle, ext_run,
         update_request_source, trigger_irq_enable, trigger_dma_enable, compare_ctrl_preload, ext_clock2_enable,
         commutation_update_select, ext_trigger_polarity, halt_freeze_select, count_run_set, count_run_clear,
         trigger_flag_clear} = 18'h0;
        {ch1_input_filter, ch2_input_filter, ext_trigger_filter, ch1_source_select, ch2_source_select} = 16'h0;
        {ext_trigger_prescale, toggle_sel, ch2_compare_mode, master_mode_select} = 10'h0;
        {slave_mode_select, trigger_select, ch2_compare, prescale, auto_reload} = 54'hFFFF;
        // tests need well under 1000 cycles
        #(50 * 4000);
        mismatches = mismatches + 1;
        report_and_stop;
    end
    always @(posedge clk)
    begin
        n_irq <= n_irq + trigger_irq_q;
        n_dma <= n_dma + trigger_dma_q;
        n_upd <= n_upd + update_event_q;
        n_com <= n_com + commutation_q;
    end
    task chk(input ok, input [8*24-1:0] m);
    begin
        num_checks = num_checks + 1;
        if (ok !== 1'h1)
        begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: %0s", $time, m);
        end
    end
    endtask
    task do_reset;
    begin
        reset = 1'h1;
        repeat (20) @(negedge clk);
        reset = 1'h0;
    end
    endtask
    // strobe order: run set, run clear, flag clear
    task pulse(input [2:0] w);
    begin
        @(negedge clk) {count_run_set, count_run_clear, trigger_flag_clear} = w;
        @(negedge clk) {count_run_set, count_run_clear, trigger_flag_clear} = 3'h0;
    end
    endtask
    task hall(input [1:0] p);
    begin
        @(posedge clk) {toggle_sel, toggle} <= {p, 1'h1};
        @(posedge clk) toggle <= 1'h0;
    end
    endtask
    task wait_flag;
        integer i;
    begin
        for (i = 0; i < 20 && trigger_flag_q !== 1'h1; i = i + 1)
            @(negedge clk);
        chk(trigger_flag_q === 1'h1, "trigger flag missing");
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        do_reset;
        chk(count_q === 16'h0000 && {trigger_flag_q, count_run_q} === 2'h0, "reset state");
        {input_xor_select, slave_mode_select, trigger_select, ch1_source_select, ch2_compare_mode} = 12'hC9F;
        {master_mode_select, ch2_compare, trigger_irq_enable, trigger_dma_enable} = 21'h14002B;
        {compare_ctrl_preload, commutation_update_select} = 2'h3;
        pulse(3'h4);
        hall(2'h0);
        repeat (40) @(negedge clk);
        pulse(3'h1);
        hall(2'h1);
        wait_flag;
        // let the request pulses be counted and the reference fall
        repeat (2) @(negedge clk);
        chk(ch1_capture_q >= 16'd41 && ch1_capture_q <= 16'd44, "capture value");
        chk(count_q <= 16'h0002 && n_irq == 2 && n_dma == 2, "restart or requests");
        chk(n_upd == 2 && n_com == 2, "update or commutation");
        chk(master_trigger_out_q === 1'h0, "master out early");
        repeat (14) @(negedge clk);
        chk(master_trigger_out_q === 1'h1, "master out pulse");
        update_request_source = 1'h1;
        pulse(3'h1);
        hall(2'h2);
        wait_flag;
        @(negedge clk);
        chk(n_upd == 2 && count_q <= 16'h0002, "update source");
        $display("hall test done");
        do_reset;
        {input_xor_select, slave_mode_select, trigger_select, ch1_polarity, ch1_input_filter} = 12'h5BA;
        master_mode_select = 3'h3;
        // let the filtered input settle to the pin level before running
        repeat (16) @(negedge clk);
        pulse(3'h4);
        repeat (10) @(negedge clk);
        chk(count_q === 16'h0000, "count with gate closed");
        hall(2'h0);
        wait_flag;
        c1 = count_q;
        repeat (10) @(negedge clk);
        chk(count_q === c1 + 16'd10, "gated count rate");
        pulse(3'h1);
        hall(2'h0);
        wait_flag;
        repeat (2) @(negedge clk);
        c1 = count_q;
        pulse(3'h2);
        hall(2'h0);
        repeat (20) @(negedge clk);
        chk(count_q === c1, "gated count without run");
        $display("gated test done");
        do_reset;
        repeat (10) @(negedge clk);
        {slave_mode_select, trigger_select, ch2_input_filter} = 10'h361;
        hall(2'h1);
        repeat (10) @(negedge clk);
        chk({count_run_q, count_q} === 17'h0, "falling edge started");
        hall(2'h1);
        wait_flag;
        chk(count_run_q === 1'h1, "run not set");
        {halt_freeze_select, core_halted} = 2'h3;
        c1 = count_q;
        repeat (8) @(negedge clk);
        chk(count_q === c1, "halt freeze");
        core_halted = 1'h0;
        repeat (4) @(negedge clk);
        chk(count_q !== c1, "halt release");
        $display("trigger test done");
        do_reset;
        // ext pin is never chosen as trigger while it clocks the counter
        {ext_clock2_enable, slave_mode_select, trigger_select, ext_run} = 8'hEB;
        {ch1_polarity, ch1_input_filter} = 5'h00;
        repeat (20) @(negedge clk);
        chk(count_q === 16'h0000, "ext count before trigger");
        hall(2'h0);
        wait_flag;
        c1 = count_q;
        repeat (40) @(negedge clk);
        chk(count_q - c1 >= 16'd9 && count_q - c1 <= 16'd11, "ext edge count");
        $display("ext clock test done");
        report_and_stop;
    end
endmodule // timer_slave_mode_control_tb_top
